// ---- hdl/bsc_pkg.sv ----
// Constants, encodings and carriers for the boundary-scan test block
package bsc_pkg;
   localparam logic [3:0] OP_IDCODE = 4'h1;
   localparam logic [3:0] OP_PRELOAD = 4'h2;
   localparam logic [3:0] OP_CHIPRST = 4'hc;
   localparam logic [3:0] OP_BYPASS = 4'hf;
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [5:0] IDX_SYSCTL = 6'h00;
   localparam logic [5:0] IDX_RSTCAUSE = 6'h01;
   localparam int SC_JTD = 7;
   localparam int SC_PUD = 4;
   localparam logic [7:0] SC_RESET = 8'h00;
   localparam logic [7:0] SC_WMASK = 8'h13;
   localparam int RC_TEST_RESET_FLAG = 4;
   localparam logic [7:0] RC_RESET = 8'h00;
   localparam logic [2:0] JTD_WINDOW_CYC = 3'h4;
   localparam logic CLK_IDLE_EXT = 1'b0;
   localparam logic CLK_IDLE_XTAL = 1'b1;
   localparam logic CLK_IDLE_LF = 1'b1;
   localparam int TAIL_CELLS = 12;

   typedef enum logic [2:0] {
      TAP_OTHER = 3'b000,
      TAP_CAP_DR = 3'b001,
      TAP_SHIFT_DR = 3'b010,
      TAP_UPD_DR = 3'b011,
      TAP_CAP_IR = 3'b100,
      TAP_SHIFT_IR = 3'b101,
      TAP_UPD_IR = 3'b110
   } bsc_tap_e;

   typedef struct packed {
      logic ext_en;
      logic xtal_en;
      logic lf_en;
   } bsc_osc_s;

   typedef struct packed {
      logic comp_off;
      logic mux_sel;
      logic bg_en;
   } bsc_ana_s;
endpackage

// ---- hdl/bsc_top.sv ----
// Boundary-scan instructions, scan cells and their control registers
module bsc_top #(
   parameter int NPINS = 8
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [7:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK,
   input wire logic TCK,
   input wire logic TDI,
   input wire logic [2:0] TAP_STATE,
   input wire logic TEST_PORT_FUSE,
   output logic TDO,
   output logic TDO_OE,
   output logic TEST_PORT_EN,
   output logic CHIP_RESET,
   output logic PULLUP_DISABLE,
   input wire logic [3:0] RST_CAUSE_EVT,
   input wire logic [NPINS-1:0] PIN_IN,
   input wire logic [NPINS-1:0] PIN_DIR,
   input wire logic [NPINS-1:0] PIN_OUT,
   input wire logic RESET_PIN_N,
   input wire logic HV_RESET_PIN,
   input wire bsc_pkg::bsc_osc_s OSC_EN,
   input wire logic [2:0] OSC_CLK,
   input wire bsc_pkg::bsc_ana_s ANA_CTL,
   input wire logic COMP_OUT,
   output logic [NPINS-1:0] SCAN_PU,
   output logic [NPINS-1:0] SCAN_OC,
   output logic [NPINS-1:0] SCAN_OD,
   output bsc_pkg::bsc_osc_s SCAN_OSC_EN,
   output bsc_pkg::bsc_ana_s SCAN_ANA
);
   localparam int B = 3 * NPINS;
   localparam int L = B + bsc_pkg::TAIL_CELLS;
   localparam int SW = NPINS + 12;
   // Link clock idles high, so its stages reset high: no false edge
   localparam logic [SW-1:0] SYNC_IDLE =
      {{5{1'b0}}, 1'b1, {(NPINS+6){1'b0}}};

   // Two-stage synchronisers for everything outside the core clock
   logic [SW-1:0] sa_q;
   logic [SW-1:0] sb_q;
   logic [SW-1:0] raw;
   logic [NPINS-1:0] pin_s;
   logic rstn_s, hv_s, comp_s, tck_s, tdi_s, fuse_s;
   logic [2:0] oclk_s;
   bsc_pkg::bsc_tap_e tap_s;

   assign raw = {TEST_PORT_FUSE, TAP_STATE, TDI, TCK, COMP_OUT, OSC_CLK,
                 HV_RESET_PIN, RESET_PIN_N, PIN_IN};

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         sa_q <= SYNC_IDLE;
         sb_q <= SYNC_IDLE;
      end else begin
         sa_q <= raw;
         sb_q <= sa_q;
      end
   end

   assign pin_s = sb_q[NPINS-1:0];
   assign rstn_s = sb_q[NPINS];
   assign hv_s = sb_q[NPINS+1];
   assign oclk_s = sb_q[NPINS+4:NPINS+2];
   assign comp_s = sb_q[NPINS+5];
   assign tck_s = sb_q[NPINS+6];
   assign tdi_s = sb_q[NPINS+7];
   assign tap_s = bsc_pkg::bsc_tap_e'(sb_q[NPINS+10:NPINS+8]);
   assign fuse_s = sb_q[NPINS+11];

   // Registers
   logic ack_q;
   logic [31:0] dat_q;
   logic jtd_q, jtd_val_q, pud_q, vector_table_select_q, vector_change_enable_q, test_reset_flag_q;
   logic [2:0] jtd_cnt_q;
   logic [3:0] cause_q;
   logic req, wr, wr_sc, wr_rc;
   logic [5:0] idx;
   logic [7:0] sc_rd, rc_rd;

   assign req = WB_CYC & WB_STB & ~ack_q;
   assign idx = WB_ADR[7:2];
   assign wr = req & WB_WE & WB_SEL[0];
   assign wr_sc = wr & (idx == bsc_pkg::IDX_SYSCTL);
   assign wr_rc = wr & (idx == bsc_pkg::IDX_RSTCAUSE);
   assign sc_rd = {jtd_q, 2'h0, pud_q, 2'h0, vector_table_select_q, vector_change_enable_q};
   assign rc_rd = {3'h0, test_reset_flag_q, cause_q};

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= req;
         if (req) begin
            // Unmapped words answer with zero
            case (idx)
               bsc_pkg::IDX_SYSCTL: dat_q <= {24'h0, sc_rd};
               bsc_pkg::IDX_RSTCAUSE: dat_q <= {24'h0, rc_rd};
               default: dat_q <= 32'h0;
            endcase
         end
      end
   end

   assign WB_ACK = ack_q;
   assign WB_DAT_O = dat_q;

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         {pud_q, vector_table_select_q, vector_change_enable_q} <= 3'h0;
      end else if (wr_sc) begin
         pud_q <= WB_DAT_I[bsc_pkg::SC_PUD];
         vector_table_select_q <= WB_DAT_I[1];
         vector_change_enable_q <= WB_DAT_I[0];
      end
   end

   // timed double write
   // A lone write only arms the window, so a stray store cannot lock us out
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         jtd_q <= bsc_pkg::SC_RESET[bsc_pkg::SC_JTD];
         jtd_val_q <= 1'b0;
         jtd_cnt_q <= 3'h0;
      end else if (wr_sc) begin
         if (jtd_cnt_q != 3'h0 && jtd_val_q == WB_DAT_I[bsc_pkg::SC_JTD]) begin
            jtd_q <= jtd_val_q;
            jtd_cnt_q <= 3'h0;
         end else begin
            jtd_val_q <= WB_DAT_I[bsc_pkg::SC_JTD];
            jtd_cnt_q <= bsc_pkg::JTD_WINDOW_CYC;
         end
      end else if (jtd_cnt_q != 3'h0) begin
         jtd_cnt_q <= jtd_cnt_q - 3'h1;
      end
   end

   logic port_en;
   assign port_en = fuse_s & ~jtd_q;
   assign TEST_PORT_EN = port_en;
   assign PULLUP_DISABLE = pud_q;

   // Test access side, sampled by core clock edges of TCK
   logic tck_d_q, rise, fall;
   bsc_pkg::bsc_tap_e st_q;
   logic [3:0] ir_q, ir_sh_q;
   logic [L-1:0] chain_q, upd_q;
   logic [L-1:0] cap;
   logic byp_q, rst_q, tdo_q, oe_q;
   logic sel_pre, sel_rst;

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         tck_d_q <= 1'b1;
      end else begin
         tck_d_q <= tck_s;
      end
   end

   assign rise = port_en & tck_s & ~tck_d_q;
   assign fall = port_en & ~tck_s & tck_d_q;
   assign sel_pre = (ir_q == bsc_pkg::OP_PRELOAD);
   assign sel_rst = (ir_q == bsc_pkg::OP_CHIPRST);

   // State is taken mid-period, where the controller holds it still
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= bsc_pkg::TAP_OTHER;
      end else if (fall) begin
         st_q <= tap_s;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ir_q <= bsc_pkg::OP_IDCODE;
         ir_sh_q <= bsc_pkg::IR_CAPTURE;
      end else if (rise) begin
         case (st_q)
            bsc_pkg::TAP_CAP_IR: ir_sh_q <= bsc_pkg::IR_CAPTURE;
            bsc_pkg::TAP_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
            bsc_pkg::TAP_UPD_IR: ir_q <= ir_sh_q;
            default: ir_sh_q <= ir_sh_q;
         endcase
      end
   end

   // pin cells, two stages plus pull-up
   for (genvar i = 0; i < NPINS; i++) begin : g_pin
      assign cap[3*i] = ~pud_q & ~PIN_DIR[i] & PIN_OUT[i];
      assign cap[3*i+1] = PIN_DIR[i];
      assign cap[3*i+2] = pin_s[i];
      assign SCAN_PU[i] = upd_q[3*i];
      assign SCAN_OC[i] = upd_q[3*i+1];
      assign SCAN_OD[i] = upd_q[3*i+2];
   end

   assign cap[B] = rstn_s;
   assign cap[B+1] = hv_s;
   assign cap[B+2] = OSC_EN.ext_en;
   assign cap[B+3] = OSC_EN.xtal_en;
   assign cap[B+4] = OSC_EN.lf_en;
   assign cap[B+5] = OSC_EN.ext_en ? oclk_s[0] : bsc_pkg::CLK_IDLE_EXT;
   assign cap[B+6] = OSC_EN.xtal_en ? oclk_s[1] : bsc_pkg::CLK_IDLE_XTAL;
   assign cap[B+7] = OSC_EN.lf_en ? oclk_s[2] : bsc_pkg::CLK_IDLE_LF;
   assign cap[B+8] = ANA_CTL.comp_off;
   assign cap[B+9] = ANA_CTL.mux_sel;
   assign cap[B+10] = ANA_CTL.bg_en;
   assign cap[B+11] = comp_s;

   // Observe-only cells simply never reach an output
   assign SCAN_OSC_EN = {upd_q[B+2], upd_q[B+3], upd_q[B+4]};
   assign SCAN_ANA = {upd_q[B+8], upd_q[B+9], upd_q[B+10]};

   // capture and shift of the chain
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         chain_q <= '0;
      end else if (rise && sel_pre) begin
         if (st_q == bsc_pkg::TAP_CAP_DR) begin
            chain_q <= cap;
         end else if (st_q == bsc_pkg::TAP_SHIFT_DR) begin
            chain_q <= {tdi_s, chain_q[L-1:1]};
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         upd_q <= '0;
      end else if (rise && sel_pre && st_q == bsc_pkg::TAP_UPD_DR) begin
         upd_q <= chain_q;
      end
   end

   // bypass capture and shift
   // Unknown opcodes fall back to bypass to keep the chain short
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         byp_q <= 1'b0;
      end else if (rise && !sel_pre && !sel_rst) begin
         if (st_q == bsc_pkg::TAP_CAP_DR) begin
            byp_q <= 1'b0;
         end else if (st_q == bsc_pkg::TAP_SHIFT_DR) begin
            byp_q <= tdi_s;
         end
      end
   end

   // shift is its only active state
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         rst_q <= 1'b0;
      end else if (rise && sel_rst && st_q == bsc_pkg::TAP_SHIFT_DR) begin
         rst_q <= tdi_s;
      end
   end

   assign CHIP_RESET = rst_q;

   // Output changes on the falling edge, as the far end samples on rising
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         tdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (!port_en) begin
         oe_q <= 1'b0;
      end else if (fall) begin
         oe_q <= (tap_s == bsc_pkg::TAP_SHIFT_DR) ||
                 (tap_s == bsc_pkg::TAP_SHIFT_IR);
         if (tap_s == bsc_pkg::TAP_SHIFT_IR) begin
            tdo_q <= ir_sh_q[0];
         end else if (sel_pre) begin
            tdo_q <= chain_q[0];
         end else if (sel_rst) begin
            tdo_q <= rst_q;
         end else begin
            tdo_q <= byp_q;
         end
      end
   end

   assign TDO = tdo_q;
   assign TDO_OE = oe_q;

   // cleared by zero write or power-on
   // Set wins over a clearing write in the same cycle
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         test_reset_flag_q <= bsc_pkg::RC_RESET[bsc_pkg::RC_TEST_RESET_FLAG];
         cause_q <= bsc_pkg::RC_RESET[3:0];
      end else begin
         test_reset_flag_q <= (rst_q & sel_rst) |
                   (test_reset_flag_q & ~(wr_rc & ~WB_DAT_I[bsc_pkg::RC_TEST_RESET_FLAG]));
         cause_q <= RST_CAUSE_EVT | (cause_q & ~(wr_rc ? ~WB_DAT_I[3:0] : 4'h0));
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);

   sequence s_dr(bsc_pkg::bsc_tap_e s);
      rise && st_q == s;
   endsequence
   sequence s_lone_write;
      wr_sc && jtd_cnt_q == 3'h0 ##1 !wr_sc [*4];
   endsequence

   AST_PRELOAD_CAPTURE: assert property (
      s_dr(bsc_pkg::TAP_CAP_DR) ##0 sel_pre |=> chain_q == $past(cap))
      else $error("chain missed capture");
   AST_PRELOAD_UPDATE: assert property (
      s_dr(bsc_pkg::TAP_UPD_DR) ##0 sel_pre |=> upd_q == $past(chain_q))
      else $error("latches missed update");
   AST_SHIFT_LSB: assert property (
      s_dr(bsc_pkg::TAP_SHIFT_DR) ##0 sel_pre
      |=> chain_q == {$past(tdi_s), $past(chain_q[L-1:1])})
      else $error("chain shifted wrong way");
   AST_CHIPRST_SHIFT: assert property (
      s_dr(bsc_pkg::TAP_SHIFT_DR) ##0 sel_rst |=> CHIP_RESET == $past(tdi_s))
      else $error("reset bit not shifted");
   AST_BYPASS_ZERO: assert property (
      s_dr(bsc_pkg::TAP_CAP_DR) ##0 ir_q == bsc_pkg::OP_BYPASS |=> !byp_q)
      else $error("bypass not zeroed");
   AST_FLAG_SET: assert property (
      CHIP_RESET && sel_rst |=> test_reset_flag_q)
      else $error("test reset flag not set");
   AST_JTD_LONE: assert property (
      s_lone_write |-> jtd_q == $past(jtd_q, 5))
      else $error("disable bit moved on one write");
   AST_PORT_OFF: assert property (
      jtd_q || !fuse_s |=> !TDO_OE ##1 !TDO_OE)
      else $error("port active while disabled");
   AST_IR_LOAD: assert property (
      s_dr(bsc_pkg::TAP_UPD_IR) |=> ir_q == $past(ir_sh_q))
      else $error("instruction not loaded");
   AST_PULLUP: assert property (
      s_dr(bsc_pkg::TAP_CAP_DR) ##0 sel_pre
      |=> chain_q[0] == $past(~pud_q & ~PIN_DIR[0] & PIN_OUT[0]))
      else $error("pull-up cell wrong");
endmodule

// ---- test/bsc_tester.sv ----
// Scan controller model that drives the test link
module bsc_tester (
   input wire logic CORE_CLK,
   input wire logic TDO,
   input wire logic TDO_OE,
   output logic TCK,
   output logic TDI,
   output logic [2:0] TAP_STATE
);
   timeunit 1ns;
   timeprecision 1ps;
   // Link clock stands high between frames
   initial begin
      TCK = 1'b1;
      TDI = 1'b0;
      TAP_STATE = 3'h0;
   end
   // State is set well before the fall so both synchronise alike
   task automatic step(input logic [2:0] st, input logic d,
         output logic q);
      TAP_STATE <= st;
      TDI <= d;
      repeat (2) @(posedge CORE_CLK);
      TCK <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      TCK <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      // Undriven output reads as the inverse of its last level
      q = TDO_OE ? TDO : ~TDO;
   endtask
   task automatic scan(input logic ir, input int n,
         input logic [63:0] din, output logic [63:0] dout,
         output logic oe);
      logic q;
      dout = '0;
      oe = 1'b1;
      @(posedge CORE_CLK);
      step(ir ? bsc_pkg::TAP_CAP_IR : bsc_pkg::TAP_CAP_DR, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(ir ? bsc_pkg::TAP_SHIFT_IR : bsc_pkg::TAP_SHIFT_DR,
            din[i], q);
         dout[i] = q;
         oe = oe & TDO_OE;
      end
      step(ir ? bsc_pkg::TAP_UPD_IR : bsc_pkg::TAP_UPD_DR, 1'b0, q);
      // Released data line must not keep its last level
      TDI <= ~TDI;
      // Let the last rising edge reach the update stage
      repeat (2) @(posedge CORE_CLK);
   endtask
endmodule

// ---- test/bsc_top_test.sv ----
// Self-checking bench for the boundary-scan block
module bsc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NP = 8;
   localparam int B = 3 * NP;
   logic CORE_CLK, RESET, WB_CYC, WB_STB, WB_WE, WB_ACK;
   logic [7:0] WB_ADR;
   logic [3:0] WB_SEL, RST_CAUSE_EVT;
   logic [31:0] WB_DAT_I, WB_DAT_O;
   logic TCK, TDI, TDO, TDO_OE, FUSE, PORT_EN, CHIP_RESET, GLOBAL_PULLUP_DISABLE;
   logic [2:0] TAP_STATE, OSC_CLK;
   logic [NP-1:0] PIN_IN, PIN_DIR, PIN_OUT, SCAN_PU, SCAN_OC, SCAN_OD;
   logic RST_N, HV_RST, COMP_OUT;
   bsc_pkg::bsc_osc_s OSC_EN, SCAN_OSC_EN;
   bsc_pkg::bsc_ana_s ANA_CTL, SCAN_ANA;
   int n_mismatch, n_compared;
   bsc_top #(.NPINS(NP)) dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET),
      .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR),
      .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK(WB_ACK), .TCK(TCK), .TDI(TDI), .TAP_STATE(TAP_STATE),
      .TEST_PORT_FUSE(FUSE), .TDO(TDO), .TDO_OE(TDO_OE),
      .TEST_PORT_EN(PORT_EN), .CHIP_RESET(CHIP_RESET),
      .PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE), .RST_CAUSE_EVT(RST_CAUSE_EVT),
      .PIN_IN(PIN_IN), .PIN_DIR(PIN_DIR), .PIN_OUT(PIN_OUT),
      .RESET_PIN_N(RST_N), .HV_RESET_PIN(HV_RST), .OSC_EN(OSC_EN),
      .OSC_CLK(OSC_CLK), .ANA_CTL(ANA_CTL), .COMP_OUT(COMP_OUT),
      .SCAN_PU(SCAN_PU), .SCAN_OC(SCAN_OC), .SCAN_OD(SCAN_OD),
      .SCAN_OSC_EN(SCAN_OSC_EN), .SCAN_ANA(SCAN_ANA));
   bsc_tester tap_u (.CORE_CLK(CORE_CLK), .TDO(TDO), .TDO_OE(TDO_OE),
      .TCK(TCK), .TDI(TDI), .TAP_STATE(TAP_STATE));
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   task automatic chk(input string what, input logic [63:0] e,
         input logic [63:0] got);
      n_compared++;
      if (got !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic wb(input logic we, input logic [5:0] idx,
         input logic [7:0] wd, output logic [31:0] rd);
      int t;
      @(posedge CORE_CLK);
      {WB_CYC, WB_STB, WB_WE, WB_ADR} <= {2'h3, we, idx, 2'h0};
      {WB_SEL, WB_DAT_I} <= {4'h1, 24'h0, wd};
      t = 0;
      do begin
         @(posedge CORE_CLK);
         t++;
      end while (WB_ACK !== 1'b1 && t < 20);
      rd = WB_DAT_O;
      {WB_CYC, WB_STB} <= 2'h0;
      if (t >= 20)
         n_mismatch++;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, idx, d, r);
   endtask
   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
      logic [31:0] r;
      wb(1'b0, idx, 8'h00, r);
      chk($sformatf("reg %0h", idx), {56'h0, e}, r);
   endtask
   task automatic t_regs();
      rd_chk(6'h00, bsc_pkg::SC_RESET);
      rd_chk(6'h01, bsc_pkg::RC_RESET);
      wr(6'h00, 8'hff);
      rd_chk(6'h00, 8'h13);
      chk("pullup_disable", 1'b1, GLOBAL_PULLUP_DISABLE);
      wr(6'h05, 8'hff);
      rd_chk(6'h05, 8'h00);
      wr(6'h00, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_disable();
      logic [63:0] d;
      logic oe;
      wr(6'h00, 8'h80);
      wr(6'h00, 8'h80);
      rd_chk(6'h00, 8'h80);
      chk("port_en", 1'b0, PORT_EN);
      tap_u.scan(1'b0, 3, 64'h5, d, oe);
      chk("tdo_oe", 1'b0, oe);
      wr(6'h00, 8'h00);
      wr(6'h00, 8'h00);
      chk("port_en", 1'b1, PORT_EN);
      FUSE <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      chk("port_en", 1'b0, PORT_EN);
      FUSE <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      $display("test disable done");
   endtask
   task automatic t_bypass();
      logic [63:0] d;
      logic oe;
      tap_u.scan(1'b1, 4, {60'h0, bsc_pkg::OP_BYPASS}, d, oe);
      chk("ir_capture", bsc_pkg::IR_CAPTURE, d);
      tap_u.scan(1'b0, 6, 64'h2d, d, oe);
      chk("bypass", (64'h2d << 1) & 64'h3f, d);
      chk("tdo_oe", 1'b1, oe);
      $display("test bypass done");
   endtask
   task automatic t_preload();
      logic [63:0] din, d, e, pu, oc, od;
      logic [2:0] ox, ax;
      logic oe;
      din = 64'h925a5c33c;
      for (int p = 0; p < 2; p++) begin
         wr(6'h00, p ? 8'h10 : 8'h00);
         @(posedge CORE_CLK);
         {PIN_IN, PIN_DIR, PIN_OUT} <= {p ? 8'ha5 : 8'h5a, 16'h0f33};
         // One main clock enabled at a time
         OSC_EN <= p ? 3'b010 : 3'b100;
         {RST_N, HV_RST, OSC_CLK} <= {p[0], ~p[0], 3'b001};
         {ANA_CTL, COMP_OUT} <= {3'b101, 1'b1};
         repeat (6) @(posedge CORE_CLK);
         {e, pu, oc, od} = '0;
         for (int i = 0; i < NP; i++) begin
            e[3*i] = ~p[0] & ~PIN_DIR[i] & PIN_OUT[i];
            e[3*i+1] = PIN_DIR[i];
            e[3*i+2] = PIN_IN[i];
            {pu[i], oc[i], od[i]} = {din[3*i], din[3*i+1], din[3*i+2]};
         end
         e[B +: 12] = {COMP_OUT, ANA_CTL.bg_en, ANA_CTL.mux_sel,
            ANA_CTL.comp_off,
            OSC_EN.lf_en ? OSC_CLK[2] : bsc_pkg::CLK_IDLE_LF,
            OSC_EN.xtal_en ? OSC_CLK[1] : bsc_pkg::CLK_IDLE_XTAL,
            OSC_EN.ext_en ? OSC_CLK[0] : bsc_pkg::CLK_IDLE_EXT,
            OSC_EN.lf_en, OSC_EN.xtal_en, OSC_EN.ext_en, HV_RST, RST_N};
         ox = {din[B+2], din[B+3], din[B+4]};
         ax = {din[B+8], din[B+9], din[B+10]};
         tap_u.scan(1'b1, 4, {60'h0, bsc_pkg::OP_PRELOAD}, d, oe);
         tap_u.scan(1'b0, B + 12, din, d, oe);
         chk("capture", e, d);
         chk("pu_latch", pu, SCAN_PU);
         chk("oc_latch", oc, SCAN_OC);
         chk("od_latch", od, SCAN_OD);
         chk("osc_latch", ox, SCAN_OSC_EN);
         chk("ana_latch", ax, SCAN_ANA);
         chk("chip_reset", 1'b0, CHIP_RESET);
         din = din ^ 64'hffffff;
      end
      $display("test preload done");
   endtask
   task automatic t_chiprst();
      logic [63:0] d;
      logic oe;
      tap_u.scan(1'b1, 4, {60'h0, bsc_pkg::OP_CHIPRST}, d, oe);
      tap_u.scan(1'b0, 1, 64'h1, d, oe);
      chk("reset_bit_old", 1'b0, d);
      chk("chip_reset", 1'b1, CHIP_RESET);
      rd_chk(6'h01, 8'h10);
      tap_u.scan(1'b0, 1, 64'h0, d, oe);
      chk("reset_bit", 1'b1, d);
      chk("chip_reset", 1'b0, CHIP_RESET);
      wr(6'h01, 8'h10);
      rd_chk(6'h01, 8'h10);
      wr(6'h01, 8'h00);
      rd_chk(6'h01, 8'h00);
      @(posedge CORE_CLK);
      RST_CAUSE_EVT <= 4'h5;
      @(posedge CORE_CLK);
      RST_CAUSE_EVT <= 4'h0;
      rd_chk(6'h01, 8'h05);
      tap_u.scan(1'b0, 1, 64'h1, d, oe);
      RESET <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RESET <= 1'b0;
      rd_chk(6'h01, 8'h00);
      chk("chip_reset", 1'b0, CHIP_RESET);
      $display("test chip reset done");
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      RESET = 1'b1;
      {WB_CYC, WB_STB, WB_WE, WB_ADR, WB_SEL, WB_DAT_I} = '0;
      {PIN_IN, PIN_DIR, PIN_OUT, OSC_EN, OSC_CLK, ANA_CTL} = '0;
      {COMP_OUT, RST_CAUSE_EVT} = '0;
      {RST_N, HV_RST, FUSE} = 3'h7;
      {n_mismatch, n_compared} = '0;
      repeat (4) @(posedge CORE_CLK);
      RESET <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      t_regs();
      t_disable();
      t_bypass();
      t_preload();
      t_chiprst();
      wrap_up();
   end
   // Whole run needs well under a tenth of this span
   initial begin
      #300000;
      n_mismatch++;
      wrap_up();
   end
endmodule
